/* File: sif_top.sv */
// Servo input functions and tuning parameters
`timescale 1ns/1ns
`include "sif_params.svh"
module sif_top (
  // Clock, reset, enable
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_clk_en,
  // Digital inputs from controller
  input  wire logic [3:0]  i_di,
  // Drive measurements
  input  wire logic [15:0] i_dc_bus_volt,
  input  wire logic [15:0] i_motor_speed,
  // AXI4-Lite write address
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [15:0] i_awaddr,
  input  wire logic [2:0]  i_awprot,
  // AXI4-Lite write data
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  // AXI4-Lite write response
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  // AXI4-Lite read address
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [15:0] i_araddr,
  input  wire logic [2:0]  i_arprot,
  // AXI4-Lite read data
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  // Function outputs
  output logic             o_servo_on,
  output logic             o_uv_alarm,
  output logic             o_alarm_cleared,
  output logic             o_gain_high,
  output logic             o_pulse_clear,
  output logic             o_zero_clamp,
  output logic             o_irq,
  // Offsets applied downstream
  output logic [15:0]      o_monitor_out_a,
  output logic [15:0]      o_monitor_out_b,
  output logic [15:0]      o_speed_offset,
  output logic [15:0]      o_torque_offset
);

  // Registered and next state
  sif_pkg::sif_state_t state_reg;
  sif_pkg::sif_state_t state_next;

  // Decoded input events
  logic       servo_lvl;
  logic       alm_rise;
  logic       gain_lvl;
  logic       pclr_lvl;
  logic       pclr_rise;
  logic       zc_lvl;
  logic       uv_cond;
  logic       do_wr;
  logic       prst;
  logic [2:0] irq_ev;
  logic [2:0] irq_clr;
  logic [15:0] wval;

  // Any input carrying code that is set in mask
  function automatic logic fn_hit(
    input logic [31:0] func,
    input logic [3:0]  mask,
    input logic [7:0]  code
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (mask[i] && func[i*8 +: 8] == code) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : fn_hit

  // Signed range check
  function automatic logic in_range(
    input logic [15:0] val,
    input logic [15:0] lo,
    input logic [15:0] hi
  );
    return ($signed(val) >= $signed(lo)) &&
           ($signed(val) <= $signed(hi));
  endfunction : in_range

  // Byte-lane merge into a 16-bit field
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    logic [15:0] v;
    v = old;
    if (strb[0]) begin
      v[7:0] = data[7:0];
    end
    if (strb[1]) begin
      v[15:8] = data[15:8];
    end
    return v;
  endfunction : merge16

  // Bus below level times root two, squared form
  function automatic logic uv_low(
    input logic [15:0] dc,
    input logic [15:0] lvl
  );
    logic [33:0] dc_sq;
    logic [33:0] lv_sq;
    // Full-width products, doubled level square
    dc_sq = 34'(dc) * 34'(dc);
    lv_sq = (34'(lvl) * 34'(lvl)) << 1;
    return dc_sq < lv_sq;
  endfunction : uv_low

  // Magnitude of a signed speed
  function automatic logic [15:0] abs16(
    input logic [15:0] v
  );
    return v[15] ? 16'(-v) : v;
  endfunction : abs16

  // Register read mux
  function automatic logic [31:0] rd_mux(
    input sif_pkg::sif_state_t s,
    input logic [13:0]         idx
  );
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (idx)
      `SIF_IDX_MON_A:    d[15:0] = s.mon_a;
      `SIF_IDX_MON_B:    d[15:0] = s.mon_b;
      `SIF_IDX_SPD_OFS:  d[15:0] = s.spd_ofs;
      `SIF_IDX_TRQ_OFS:  d[15:0] = s.trq_ofs;
      `SIF_IDX_UV_LVL:   d[15:0] = s.uv_level;
      `SIF_IDX_ZERO_SPD: d[15:0] = s.zero_spd;
      `SIF_IDX_DI_FUNC:  d = s.di_func;
      `SIF_IDX_IRQ_STAT: d[2:0] = s.irq_stat;
      `SIF_IDX_IRQ_MASK: d[2:0] = s.irq_mask;
      `SIF_IDX_CTRL: begin
        d[`SIF_CTRL_MODE_LSB +: 2] = s.mode;
        d[`SIF_CTRL_GSEL_LSB +: 4] = s.gain_sel;
        d[`SIF_CTRL_CLR_LVL]       = s.clr_level;
      end
      `SIF_IDX_STATUS: begin
        d[0]    = s.outs.servo_on;
        d[1]    = s.outs.alarm;
        d[2]    = s.outs.gain_high;
        d[3]    = s.outs.pulse_clear;
        d[4]    = s.outs.zero_clamp;
        d[11:8] = s.di_s2;
      end
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction : rd_mux

  // Known register index
  function automatic logic mapped(
    input logic [13:0] idx
  );
    return (idx >= `SIF_IDX_MON_A && idx <= `SIF_IDX_UV_LVL &&
            idx[0] == 1'b0 && idx != 14'h0432) ||
           (idx >= `SIF_IDX_CTRL && idx <= `SIF_IDX_IRQ_MASK);
  endfunction : mapped

  // Next-state logic
  always_comb begin
    state_next = state_reg;
    // Two-stage sync, then previous sample
    state_next.di_s1   = i_di;           // R10
    state_next.di_s2   = state_reg.di_s1;
    state_next.di_prev = state_reg.di_s2;
    // Input function decode on synced levels
    servo_lvl = fn_hit(state_reg.di_func, state_reg.di_s2,
                       `SIF_FN_SERVO_ON);
    alm_rise  = fn_hit(state_reg.di_func,
                       state_reg.di_s2 & ~state_reg.di_prev,
                       `SIF_FN_ALM_CLR); // R10
    gain_lvl  = fn_hit(state_reg.di_func, state_reg.di_s2,
                       `SIF_FN_GAIN_SW);
    pclr_lvl  = fn_hit(state_reg.di_func, state_reg.di_s2,
                       `SIF_FN_PCLR);
    pclr_rise = fn_hit(state_reg.di_func,
                       state_reg.di_s2 & ~state_reg.di_prev,
                       `SIF_FN_PCLR);
    zc_lvl    = fn_hit(state_reg.di_func, state_reg.di_s2,
                       `SIF_FN_ZERO_SPEED_HOLD_INPUT);
    uv_cond   = uv_low(i_dc_bus_volt, state_reg.uv_level); // R4

    // Bus address and data capture
    if (i_awvalid && state_reg.axi.awready) begin
      state_next.axi.aw_have = 1'b1;
      state_next.axi.aw_idx  = i_awaddr[15:2];
    end
    if (i_wvalid && state_reg.axi.wready) begin
      state_next.axi.w_have = 1'b1;
      state_next.axi.wdata  = i_wdata;
      state_next.axi.wstrb  = i_wstrb;
    end
    if (state_reg.axi.bvalid && i_bready) begin
      state_next.axi.bvalid = 1'b0;
    end

    // Register write once both halves held
    do_wr   = state_reg.axi.aw_have && state_reg.axi.w_have &&
              !state_reg.axi.bvalid;
    prst    = 1'b0;
    irq_clr = 3'h0;
    wval    = merge16(16'h0000, state_reg.axi.wdata,
                      state_reg.axi.wstrb);
    if (do_wr) begin
      state_next.axi.aw_have = 1'b0;
      state_next.axi.w_have  = 1'b0;
      state_next.axi.bvalid  = 1'b1;
      state_next.axi.bresp   = mapped(state_reg.axi.aw_idx) ?
                               `SIF_RESP_OKAY : `SIF_RESP_SLVERR;
      unique case (state_reg.axi.aw_idx)
        // Out-of-range values are dropped
        `SIF_IDX_MON_A: begin
          wval = merge16(state_reg.mon_a, state_reg.axi.wdata,
                         state_reg.axi.wstrb);
          if (in_range(wval, `SIF_MON_MIN, `SIF_MON_MAX)) begin
            state_next.mon_a = wval; // R1
          end
        end
        `SIF_IDX_MON_B: begin
          wval = merge16(state_reg.mon_b, state_reg.axi.wdata,
                         state_reg.axi.wstrb);
          if (in_range(wval, `SIF_MON_MIN, `SIF_MON_MAX)) begin
            state_next.mon_b = wval; // R1
          end
        end
        `SIF_IDX_SPD_OFS: begin
          wval = merge16(state_reg.spd_ofs, state_reg.axi.wdata,
                         state_reg.axi.wstrb);
          if (in_range(wval, `SIF_OFS_MIN, `SIF_OFS_MAX)) begin
            state_next.spd_ofs = wval; // R2
          end
        end
        `SIF_IDX_TRQ_OFS: begin
          wval = merge16(state_reg.trq_ofs, state_reg.axi.wdata,
                         state_reg.axi.wstrb);
          if (in_range(wval, `SIF_OFS_MIN, `SIF_OFS_MAX)) begin
            state_next.trq_ofs = wval; // R2
          end
        end
        `SIF_IDX_UV_LVL: begin
          wval = merge16(state_reg.uv_level, state_reg.axi.wdata,
                         state_reg.axi.wstrb);
          if (in_range(wval, `SIF_UV_MIN, `SIF_UV_MAX)) begin
            state_next.uv_level = wval; // R3
          end
        end
        `SIF_IDX_ZERO_SPD: begin
          state_next.zero_spd = wval;
        end
        `SIF_IDX_CTRL: begin
          // Mode code 3 is illegal and ignored
          if (state_reg.axi.wstrb[0] &&
              state_reg.axi.wdata[1:0] != 2'h3) begin
            state_next.mode = sif_pkg::sif_mode_t'(
              state_reg.axi.wdata[`SIF_CTRL_MODE_LSB +: 2]);
          end
          if (state_reg.axi.wstrb[0]) begin
            state_next.gain_sel =
              state_reg.axi.wdata[`SIF_CTRL_GSEL_LSB +: 4];
          end
          if (state_reg.axi.wstrb[1]) begin
            state_next.clr_level =
              state_reg.axi.wdata[`SIF_CTRL_CLR_LVL];
            prst = state_reg.axi.wdata[`SIF_CTRL_PRST];
          end
        end
        `SIF_IDX_DI_FUNC: begin
          for (int b = 0; b < 4; b++) begin
            if (state_reg.axi.wstrb[b]) begin
              state_next.di_func[b*8 +: 8] =
                state_reg.axi.wdata[b*8 +: 8];
            end
          end
        end
        `SIF_IDX_IRQ_STAT: begin
          if (state_reg.axi.wstrb[0]) begin
            irq_clr = state_reg.axi.wdata[2:0];
          end
        end
        `SIF_IDX_IRQ_MASK: begin
          if (state_reg.axi.wstrb[0]) begin
            state_next.irq_mask = state_reg.axi.wdata[2:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Parameter reset spares monitor offsets
    if (prst) begin
      state_next.spd_ofs  = 16'h0000;    // R2
      state_next.trq_ofs  = 16'h0000;    // R2
      state_next.uv_level = `SIF_UV_DEF; // R3
    end

    // Read channel, one beat at a time
    if (state_reg.axi.rvalid && i_rready) begin
      state_next.axi.rvalid = 1'b0;
    end
    if (i_arvalid && state_reg.axi.arready) begin
      state_next.axi.rvalid = 1'b1;
      state_next.axi.rdata  = rd_mux(state_reg, i_araddr[15:2]);
      state_next.axi.rresp  = mapped(i_araddr[15:2]) ?
                              `SIF_RESP_OKAY : `SIF_RESP_SLVERR;
    end
    state_next.axi.awready = !state_next.axi.aw_have;
    state_next.axi.wready  = !state_next.axi.w_have;
    state_next.axi.arready = !state_next.axi.rvalid;

    // Alarm: cause sets, edge clears once cause gone
    state_next.outs.alarm_cleared = 1'b0;
    if (alm_rise && !uv_cond && state_reg.outs.alarm) begin
      state_next.outs.alarm         = 1'b0; // R6
      state_next.outs.alarm_cleared = 1'b1; // R6
    end
    if (uv_cond) begin
      state_next.outs.alarm = 1'b1; // R4
    end

    // Level and edge functions
    state_next.outs.servo_on  = servo_lvl; // R5
    state_next.outs.gain_high = gain_lvl &&
      state_reg.gain_sel == `SIF_GSEL_ON &&
      state_reg.mode != sif_pkg::SIF_MODE_T; // R7
    state_next.outs.pulse_clear =
      state_reg.mode == sif_pkg::SIF_MODE_PT &&
      (state_reg.clr_level ? pclr_lvl : pclr_rise); // R8
    state_next.outs.zero_clamp = zc_lvl &&
      state_reg.mode == sif_pkg::SIF_MODE_S &&
      abs16(i_motor_speed) < state_reg.zero_spd; // R9

    // Offsets only in their own mode
    state_next.outs.spd_apply =
      (state_reg.mode == sif_pkg::SIF_MODE_S) ?
      state_reg.spd_ofs : 16'h0000; // R2
    state_next.outs.trq_apply =
      (state_reg.mode == sif_pkg::SIF_MODE_T) ?
      state_reg.trq_ofs : 16'h0000; // R2

    // Sticky events, set beats clear
    irq_ev = {state_next.outs.pulse_clear,
              state_next.outs.alarm_cleared,
              uv_cond && !state_reg.outs.alarm};
    state_next.irq_stat = (state_reg.irq_stat & ~irq_clr) | irq_ev;
    state_next.outs.irq = |(state_next.irq_stat &
                            state_next.irq_mask);
  end

  // State register, synchronous reset
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_reg             <= '0;
      state_reg.uv_level    <= `SIF_UV_DEF;
      state_reg.axi.awready <= 1'b1;
      state_reg.axi.wready  <= 1'b1;
      state_reg.axi.arready <= 1'b1;
    end else if (i_clk_en) begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from state
  assign o_awready       = state_reg.axi.awready;
  assign o_wready        = state_reg.axi.wready;
  assign o_bvalid        = state_reg.axi.bvalid;
  assign o_bresp         = state_reg.axi.bresp;
  assign o_arready       = state_reg.axi.arready;
  assign o_rvalid        = state_reg.axi.rvalid;
  assign o_rdata         = state_reg.axi.rdata;
  assign o_rresp         = state_reg.axi.rresp;
  assign o_servo_on      = state_reg.outs.servo_on;
  assign o_uv_alarm      = state_reg.outs.alarm;
  assign o_alarm_cleared = state_reg.outs.alarm_cleared;
  assign o_gain_high     = state_reg.outs.gain_high;
  assign o_pulse_clear   = state_reg.outs.pulse_clear;
  assign o_zero_clamp    = state_reg.outs.zero_clamp;
  assign o_irq           = state_reg.outs.irq;
  assign o_monitor_out_a = state_reg.mon_a;
  assign o_monitor_out_b = state_reg.mon_b;
  assign o_speed_offset  = state_reg.outs.spd_apply;
  assign o_torque_offset = state_reg.outs.trq_apply;

endmodule : sif_top

/* File: sif_params.svh */
// Constants of the servo input function block
// Behaviour
// R1 - Two monitor offsets, -800..800, survive parameter reset
// R2 - Speed/torque input offsets, -5000..5000, default zero
// R3 - Undervoltage level 140..190 V rms, default 160
// R4 - Alarm when bus below level times root two
// R5 - Code 0x01: servo on while input on
// R6 - Code 0x02: rising edge clears alarm if gone
// R7 - Code 0x03: gain switch in PT/S when select 1
// R8 - Code 0x04: clear pulse counter, PT, edge/level
// R9 - Code 0x05: zero clamp below threshold, speed mode
// R10 - Synchronise inputs, edge by sample compare
// R11 - Controller holds levels several sample periods
`ifndef SIF_PARAMS_SVH
`define SIF_PARAMS_SVH
// Register indices, byte address is index times four
`define SIF_IDX_MON_A    14'h0428
`define SIF_IDX_MON_B    14'h042a
`define SIF_IDX_SPD_OFS  14'h042c
`define SIF_IDX_TRQ_OFS  14'h042e
`define SIF_IDX_UV_LVL   14'h0430
`define SIF_IDX_CTRL     14'h0500
`define SIF_IDX_ZERO_SPD 14'h0501
`define SIF_IDX_DI_FUNC  14'h0502
`define SIF_IDX_STATUS   14'h0503
`define SIF_IDX_IRQ_STAT 14'h0504
`define SIF_IDX_IRQ_MASK 14'h0505
// Value ranges and defaults
`define SIF_MON_MIN 16'hfce0
`define SIF_MON_MAX 16'h0320
`define SIF_OFS_MIN 16'hec78
`define SIF_OFS_MAX 16'h1388
`define SIF_UV_MIN  16'h008c
`define SIF_UV_MAX  16'h00be
`define SIF_UV_DEF  16'h00a0
// Control register fields
`define SIF_CTRL_MODE_LSB 0
`define SIF_CTRL_GSEL_LSB 4
`define SIF_CTRL_CLR_LVL  8
`define SIF_CTRL_PRST     15
`define SIF_GSEL_ON       4'h1
// Input function codes
`define SIF_FN_SERVO_ON 8'h01
`define SIF_FN_ALM_CLR  8'h02
`define SIF_FN_GAIN_SW  8'h03
`define SIF_FN_PCLR     8'h04
`define SIF_FN_ZERO_SPEED_HOLD_INPUT   8'h05
// Bus answers
`define SIF_RESP_OKAY   2'h0
`define SIF_RESP_SLVERR 2'h2
`endif

/* File: sif_pkg.sv */
// Types of the servo input function block
package sif_pkg;
  // Control modes
  typedef enum logic [1:0] {
    SIF_MODE_PT = 2'h0,
    SIF_MODE_S  = 2'h1,
    SIF_MODE_T  = 2'h2
  } sif_mode_t;

  // Function outputs toward the drive
  typedef struct packed {
    logic        servo_on;
    logic        alarm;
    logic        alarm_cleared;
    logic        gain_high;
    logic        pulse_clear;
    logic        zero_clamp;
    logic        irq;
    logic [15:0] spd_apply;
    logic [15:0] trq_apply;
  } sif_out_t;

  // Bus slave holding state
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        arready;
    logic        aw_have;
    logic        w_have;
    logic [13:0] aw_idx;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sif_axi_t;

  // Whole block state
  typedef struct packed {
    logic [15:0] mon_a;
    logic [15:0] mon_b;
    logic [15:0] spd_ofs;
    logic [15:0] trq_ofs;
    logic [15:0] uv_level;
    logic [15:0] zero_spd;
    sif_mode_t   mode;
    logic [3:0]  gain_sel;
    logic        clr_level;
    logic [31:0] di_func;
    logic [3:0]  di_s1;
    logic [3:0]  di_s2;
    logic [3:0]  di_prev;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    sif_out_t    outs;
    sif_axi_t    axi;
  } sif_state_t;
endpackage : sif_pkg

/* File: sif_chk.sv */
// Port checker of the servo input function block
`timescale 1ns/1ns
module sif_chk (
  // Clock, reset, enable
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  input wire logic        i_clk_en,
  // Bus handshakes
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic [1:0]  o_bresp,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic [31:0] o_rdata,
  // Function side
  input wire logic [15:0] i_dc_bus_volt,
  input wire logic        o_uv_alarm,
  input wire logic        o_alarm_cleared,
  input wire logic        o_gain_high,
  input wire logic        o_pulse_clear,
  input wire logic        o_zero_clamp,
  input wire logic [15:0] o_speed_offset,
  input wire logic [15:0] o_torque_offset
);
  // One domain only
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  // Response held until taken
  chk_b_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response not held");
  chk_r_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data not held");
  // Fixed answer latency
  chk_r_answer: assert property (i_arvalid && o_arready && i_clk_en |=> o_rvalid)
    else $error("read answer late");
  chk_b_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready && i_clk_en |-> ##2 o_bvalid)
    else $error("write answer late");
  // No new address while answering
  chk_ar_block: assert property (o_rvalid |-> !o_arready && !$rose(o_arready))
    else $error("read address open during answer");
  // Bus just above the highest threshold never raises alarm
  chk_uv_high: assert property (!o_uv_alarm && i_dc_bus_volt >= 16'h010d |=> !o_uv_alarm)
    else $error("alarm with healthy bus");
  // Bus below lowest threshold raises alarm
  chk_uv_low: assert property (i_dc_bus_volt <= 16'h00c5 && i_clk_en |-> ##[1:3] o_uv_alarm)
    else $error("alarm missing with low bus");
  // Clear report only with alarm gone
  chk_clr_alarm: assert property (o_alarm_cleared |-> !o_uv_alarm)
    else $error("clear reported with alarm set");
  chk_clr_pulse: assert property (o_alarm_cleared && i_clk_en |=> !o_alarm_cleared)
    else $error("clear report longer than a cycle");
  // Torque mode disables position and speed functions
  chk_t_mode: assert property (o_torque_offset != 16'h0000 |-> !o_gain_high && !o_zero_clamp && !o_pulse_clear)
    else $error("function active in torque mode");
  // Speed mode excludes torque offset and pulse clear
  chk_s_mode: assert property (o_speed_offset != 16'h0000 |-> o_torque_offset == 16'h0000 && !o_pulse_clear)
    else $error("speed mode overlap");
endmodule : sif_chk

bind sif_top sif_chk u_chk (.*);

/* File: sif_ctrl_model.sv */
// Motion controller model driving the digital inputs
`timescale 1ns/1ns
module sif_ctrl_model (
  // Clock and wanted levels
  input  wire logic       i_core_clk,
  input  wire logic [3:0] i_want,
  // Digital input lines
  output logic [3:0]      o_di
);
  logic [2:0] hold_reg = 3'h0; // Cycles since last change
  initial o_di = 4'h0;
  // New level only once the old one stood long enough
  always @(posedge i_core_clk) begin
    if (hold_reg < 3'h4) begin
      hold_reg <= hold_reg + 3'h1;
    end else if (i_want != o_di) begin
      o_di     <= i_want;
      hold_reg <= 3'h0;
    end
  end
endmodule : sif_ctrl_model

/* File: sif_bench.sv */
// Self-checking bench of the servo input function block
`timescale 1ns/1ns
`include "sif_params.svh"
module servo_input_function_params_test;
  // Bench row: write flag, index, data, expected answers
  typedef struct packed {
    logic        w;
    logic [13:0] ix;
    logic [31:0] d;
    logic [1:0]  br;
    logic [31:0] q;
    logic [1:0]  rr;
  } sif_row_t;
  // Design ports, reset and handshakes driven low at start
  logic        i_core_clk, i_rst_n = 1'b0, i_clk_en = 1'b1;
  logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic        o_servo_on, o_uv_alarm, o_alarm_cleared, o_gain_high, o_pulse_clear, o_zero_clamp;
  logic [1:0]  o_bresp, o_rresp, rs;
  logic [2:0]  i_awprot = 3'h0, i_arprot = 3'h0;
  logic [3:0]  i_di, i_wstrb = 4'hf, want = 4'h0;
  logic [15:0] i_awaddr = 16'h0, i_araddr = 16'h0, i_dc_bus_volt = 16'h010d, i_motor_speed = 16'h0;
  logic [15:0] o_monitor_out_a, o_monitor_out_b, o_speed_offset, o_torque_offset;
  logic [31:0] i_wdata = 32'h0, o_rdata, rd;
  int          failures, comparisons, n, cp, ca;
  // Register cases
  sif_row_t rows [17] = '{
    '{1'b0, `SIF_IDX_MON_B, 32'h0, 2'h0, 32'h0, 2'h0}, '{1'b0, `SIF_IDX_SPD_OFS, 32'h0, 2'h0, 32'h0, 2'h0},
    '{1'b0, `SIF_IDX_TRQ_OFS, 32'h0, 2'h0, 32'h0, 2'h0}, '{1'b0, `SIF_IDX_UV_LVL, 32'h0, 2'h0, 32'ha0, 2'h0},
    '{1'b1, `SIF_IDX_MON_A, 32'h320, 2'h0, 32'h320, 2'h0}, '{1'b1, `SIF_IDX_MON_A, 32'hfce0, 2'h0, 32'hfce0, 2'h0},
    '{1'b1, `SIF_IDX_MON_A, 32'h321, 2'h0, 32'hfce0, 2'h0}, '{1'b1, `SIF_IDX_MON_B, 32'hfcdf, 2'h0, 32'h0, 2'h0},
    '{1'b1, `SIF_IDX_SPD_OFS, 32'h1388, 2'h0, 32'h1388, 2'h0}, '{1'b1, `SIF_IDX_SPD_OFS, 32'h1389, 2'h0, 32'h1388, 2'h0},
    '{1'b1, `SIF_IDX_TRQ_OFS, 32'hec78, 2'h0, 32'hec78, 2'h0}, '{1'b1, `SIF_IDX_TRQ_OFS, 32'hec77, 2'h0, 32'hec78, 2'h0},
    '{1'b1, `SIF_IDX_UV_LVL, 32'h8b, 2'h0, 32'ha0, 2'h0}, '{1'b1, `SIF_IDX_UV_LVL, 32'hbe, 2'h0, 32'hbe, 2'h0},
    '{1'b1, `SIF_IDX_UV_LVL, 32'hbf, 2'h0, 32'hbe, 2'h0}, '{1'b1, `SIF_IDX_UV_LVL, 32'h8c, 2'h0, 32'h8c, 2'h0},
    '{1'b1, 14'h0431, 32'h1, `SIF_RESP_SLVERR, 32'h0, `SIF_RESP_SLVERR}};

  sif_top uut (.*);
  sif_ctrl_model u_ctrl (.i_core_clk(i_core_clk), .i_want(want), .o_di(i_di));

  // 50 MHz clock
  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end

  // Compare one value and count it
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Bus write, both channels offered together
  task automatic wr(input logic [13:0] ix, input logic [31:0] d, output logic [1:0] r);
    logic a, w, b;
    @(posedge i_core_clk);
    {i_awvalid, i_wvalid, i_bready} <= 3'h7;
    i_awaddr <= {ix, 2'h0};
    i_wdata  <= d;
    b = 1'b0;
    n = 0;
    while (!b && n < 40) begin
      @(negedge i_core_clk);
      {a, w, b, r} = {o_awready, o_wready, o_bvalid, o_bresp};
      @(posedge i_core_clk);
      if (a) i_awvalid <= 1'b0;
      if (w) i_wvalid <= 1'b0;
      n++;
    end
    if (!b) failures++;
    i_bready <= 1'b0;
  endtask : wr

  // Bus read into rd and rs
  task automatic rdx(input logic [13:0] ix);
    logic a, v;
    @(posedge i_core_clk);
    {i_arvalid, i_rready} <= 2'h3;
    i_araddr <= {ix, 2'h0};
    v = 1'b0;
    n = 0;
    while (!v && n < 40) begin
      @(negedge i_core_clk);
      {a, v, rd, rs} = {o_arready, o_rvalid, o_rdata, o_rresp};
      @(posedge i_core_clk);
      if (a) i_arvalid <= 1'b0;
      n++;
    end
    if (!v) failures++;
    i_rready <= 1'b0;
  endtask : rdx

  // New input levels, then count report pulses
  task automatic di(input logic [3:0] v);
    @(posedge i_core_clk);
    want <= v;
    {cp, ca} = 0;
    repeat (12) begin
      @(negedge i_core_clk);
      if (o_pulse_clear === 1'b1) cp++;
      if (o_alarm_cleared === 1'b1) ca++;
    end
  endtask : di

  // Verdict and end of run
  task automatic summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  // Hang guard
  initial begin
    #400000;
    failures++;
    summarize();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    foreach (rows[k]) begin
      if (rows[k].w) begin
        wr(rows[k].ix, rows[k].d, rs);
        chk("bresp", rs, rows[k].br);
      end
      rdx(rows[k].ix);
      chk("rdata", rd, rows[k].q);
      chk("rresp", rs, rows[k].rr);
    end
    $display("register table done");
    // Parameter reset spares monitor offsets
    chk("mon a out", o_monitor_out_a, 32'hfce0);
    chk("mon b out", o_monitor_out_b, 32'h0);
    wr(`SIF_IDX_CTRL, 32'h8000, rs);
    rdx(`SIF_IDX_SPD_OFS);
    chk("spd after prst", rd, 32'h0);
    rdx(`SIF_IDX_UV_LVL);
    chk("uv after prst", rd, 32'ha0);
    rdx(`SIF_IDX_MON_A);
    chk("mon a after prst", rd, 32'hfce0);
    $display("parameter reset done");
    // Functions in every mode, all inputs on
    wr(`SIF_IDX_SPD_OFS, 32'h64, rs);
    wr(`SIF_IDX_TRQ_OFS, 32'hc8, rs);
    wr(`SIF_IDX_ZERO_SPD, 32'ha, rs);
    wr(`SIF_IDX_DI_FUNC, 32'h05040301, rs);
    i_motor_speed <= 16'h0005;
    for (int m = 0; m < 3; m++) begin
      wr(`SIF_IDX_CTRL, 32'h110 | m, rs);
      di(4'hf);
      chk("servo", o_servo_on, 32'h1);
      chk("gain", o_gain_high, m != 2);
      chk("pclr level", o_pulse_clear, m == 0);
      chk("zero_speed_hold_input", o_zero_clamp, m == 1);
      chk("spd out", o_speed_offset, m == 1 ? 32'h64 : 32'h0);
      chk("trq out", o_torque_offset, m == 2 ? 32'hc8 : 32'h0);
    end
    // Other gain select, speed at threshold
    wr(`SIF_IDX_CTRL, 32'h121, rs);
    i_motor_speed <= 16'hfff6;
    di(4'hf);
    chk("gain sel 2", o_gain_high, 32'h0);
    chk("zero_speed_hold_input fast", o_zero_clamp, 32'h0);
    $display("mode functions done");
    // Edge-triggered pulse clear and its interrupt
    wr(`SIF_IDX_CTRL, 32'h0, rs);
    di(4'h0);
    wr(`SIF_IDX_IRQ_STAT, 32'h7, rs);
    di(4'h4);
    chk("pclr pulses", cp, 32'h1);
    chk("irq masked", o_irq, 32'h0);
    rdx(`SIF_IDX_IRQ_STAT);
    chk("irq stat", rd, 32'h4);
    wr(`SIF_IDX_IRQ_MASK, 32'h4, rs);
    di(4'h4);
    chk("irq on", o_irq, 32'h1);
    wr(`SIF_IDX_IRQ_STAT, 32'h4, rs);
    di(4'h4);
    chk("irq cleared", o_irq, 32'h0);
    $display("pulse clear done");
    // Undervoltage alarm and clearing input
    wr(`SIF_IDX_DI_FUNC, 32'h2, rs);
    i_dc_bus_volt <= 16'h00e3;
    di(4'h0);
    chk("no alarm", o_uv_alarm, 32'h0);
    @(posedge i_core_clk);
    i_dc_bus_volt <= 16'h00e2;
    di(4'h0);
    chk("alarm", o_uv_alarm, 32'h1);
    di(4'h1);
    chk("clear refused", ca, 32'h0);
    chk("alarm kept", o_uv_alarm, 32'h1);
    di(4'h0);
    @(posedge i_core_clk);
    i_dc_bus_volt <= 16'h00e3;
    di(4'h1);
    chk("clear pulses", ca, 32'h1);
    chk("alarm gone", o_uv_alarm, 32'h0);
    $display("alarm done");
    // Second reset in mid-run
    @(posedge i_core_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    rdx(`SIF_IDX_UV_LVL);
    chk("uv after reset", rd, 32'ha0);
    chk("servo after reset", o_servo_on, 32'h0);
    $display("reset done");
    summarize();
  end
endmodule : servo_input_function_params_test
